// file: hw/lock_range_check.sv
// Purpose: decides whether a block address lies in the unlocked window
// Assumes: start inclusive, end exclusive, purely combinational
// Notes: equal bounds mean no unlocked window at all
`timescale 1ns/1ps
module lock_range_check #(
	parameter int BLK_W = 24
) (
	// lock settings
	input wire logic i_lock_on,
	input wire logic [BLK_W-1:0] i_start,
	input wire logic [BLK_W-1:0] i_end,
	// address under test
	input wire logic [BLK_W-1:0] i_block,
	// verdict
	output logic o_allowed
);
	if (BLK_W < 1) begin
		$error("BLK_W must be at least 1");
	end

	always_comb begin
		if (!i_lock_on) begin
			o_allowed = 1'b1;
		end else if (i_start == i_end) begin
			o_allowed = 1'b0;
		end else begin
			o_allowed = (i_block >= i_start) && (i_block < i_end);
		end
	end
endmodule

// file: hw/nand_ctrl_control_and_lock.sv
// Purpose: control register, chip selects and write/erase lock of a flash controller
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: a wake from sleep clears the control, range and status flag registers just as reset does, but synchronously
//
// Overview of operation
// - control bit 18 picks ECC direction, 0 decode for reads, 1 encode.
// - sticky lock bit 17 only sets; reset or wake alone clear it.
// - with any lock on, writes/erases outside range are refused, reads pass whenever bit 0 enables.
// - write or erase refused on an enabled controller sets status bit 5 as illegal access.
// - locked with equal start and end means the whole flash is locked.
// - soft lock bit 16 resets to 1 and software changes it freely.
// - bit 12 gates the ECC decode completion interrupt.
// - bit 11 drives reinitialise or stop of the 8-bit ECC engine.
// - bit 10 gates the illegal access interrupt.
// - bit 9 gates the ready/busy transition interrupt.
// - bit 8 picks ready/busy edge, 0 rising, 1 falling.
// - bit 7, reset 1, freezes main-area ECC generation while set.
// - bit 6, reset 1, freezes spare-area ECC generation while set.
// - writing 1 to bit 5 clears the main ECC; the bit reads zero.
// - writing 1 to bit 4 clears the spare ECC.
// - bit 2, reset 1, drives second chip select while bit 1 is 1.
// - bit 1, reset 1, drives first chip select directly.
// - both chip selects are never asserted together.
// - boot drives first chip select; its bit counts only when enabled.
// - bit 0 enables the controller; disabled means no flash operations.
// - control register resets to 0x000100C6.
// - range registers writable under soft lock, frozen once sticky lock set.
`timescale 1ns/1ps
module nand_ctrl_control_and_lock
	import nand_ctrl_pkg::*;
#(
	parameter int BLK_W = BLK_W_DOC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wake,
	// register port
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// command check from the sequencer
	input wire logic i_cmd_valid,
	input wire logic i_cmd_modify,
	input wire logic [BLK_W-1:0] i_cmd_block,
	output logic o_cmd_grant,
	output logic o_cmd_deny,
	// boot and flash status inputs
	input wire logic i_boot_active,
	input wire logic i_boot_cs_a_n,
	input wire logic i_ready_busy_input,
	input wire logic i_ecc_done,
	// flash chip selects, active low
	output logic o_chip_sel_a_out_n,
	output logic o_chip_sel_b_out_n,
	// ECC engine control
	output logic o_enable,
	output logic o_ecc_encode,
	output logic o_main_ecc_freeze,
	output logic o_spare_ecc_freeze,
	output logic o_main_ecc_clear,
	output logic o_spare_ecc_clear,
	output logic o_octal_ecc_reinit,
	// gated event lines
	output logic o_ecc_done_irq,
	output logic o_bad_access_irq,
	output logic o_ready_busy_irq
);
	// refuse widths that the range registers and the read port cannot carry
	if (BLK_W < 1 || BLK_W > 32) begin
		$error("BLK_W must lie between 1 and 32");
	end
	// the reset value may only touch bits that are stored
	if ((CTL_RESET & ~CTL_STORED) != 32'h0000_0000) begin
		$error("control reset value sets bits that are not stored");
	end

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic wr_ctl;
	logic wr_start;
	logic wr_end;
	logic wr_stat;
	// full addresses are compared, so aliases of the block are ignored
	assign wr_ctl = i_wr && (i_addr == ADDR_FLASH_CONTROL);
	assign wr_start = i_wr && (i_addr == ADDR_UNLOCK_START);
	assign wr_end = i_wr && (i_addr == ADDR_UNLOCK_END);
	assign wr_stat = i_wr && (i_addr == ADDR_FLASH_STATUS);

	////////////////////////////////////////////////////////////////////////////
	// flash_control

	logic [31:0] ctl_reg;
	logic [31:0] ctl_next;

	always_comb begin
		ctl_next = ctl_reg;
		if (wr_ctl) begin
			// reserved and write-only bits are dropped; leaves 15:13 at zero
			ctl_next = i_wdata & CTL_STORED;
			// sticky lock: a written 0 cannot clear it
			ctl_next[CTL_STICKY_LOCK] = ctl_reg[CTL_STICKY_LOCK]
				| i_wdata[CTL_STICKY_LOCK];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_reg <= CTL_RESET;
		end else if (i_wake) begin
			// wake clears at a clock edge, unlike the asynchronous reset
			ctl_reg <= CTL_RESET;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	logic soft_lock;
	logic sticky_lock;
	logic lock_on;
	assign soft_lock = ctl_reg[CTL_SOFT_LOCK];
	assign sticky_lock = ctl_reg[CTL_STICKY_LOCK];
	// either lock alone is enough to guard the block range
	assign lock_on = soft_lock | sticky_lock;

	////////////////////////////////////////////////////////////////////////////
	// unlocked block range

	logic [BLK_W-1:0] start_reg;
	logic [BLK_W-1:0] end_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			start_reg <= BLK_RESET[BLK_W-1:0];
			end_reg <= BLK_RESET[BLK_W-1:0];
		end else if (i_wake) begin
			start_reg <= BLK_RESET[BLK_W-1:0];
			end_reg <= BLK_RESET[BLK_W-1:0];
		// the sticky lock freezes the window until reset or wake
		end else if (!sticky_lock) begin
			if (wr_start) begin
				start_reg <= i_wdata[BLK_W-1:0];
			end
			if (wr_end) begin
				end_reg <= i_wdata[BLK_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command check

	logic range_ok;

	lock_range_check #(
		.BLK_W(BLK_W)
	) u_range (
		.i_lock_on(lock_on),
		.i_start(start_reg),
		.i_end(end_reg),
		.i_block(i_cmd_block),
		.o_allowed(range_ok)
	);

	// a disabled controller refuses every command but records no fault
	logic bad_access;
	logic cmd_ok;
	// reads pass anywhere; modify commands must land in the window
	assign bad_access = i_cmd_valid && ctl_reg[CTL_ENABLE] && i_cmd_modify && !range_ok;
	assign cmd_ok = i_cmd_valid && ctl_reg[CTL_ENABLE] && (!i_cmd_modify || range_ok);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cmd_grant <= 1'b0;
			o_cmd_deny <= 1'b0;
		end else begin
			o_cmd_grant <= cmd_ok;
			o_cmd_deny <= i_cmd_valid && !cmd_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ready/busy edge detect

	logic rb_prev_reg;
	logic rb_edge;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			// ready level, so leaving reset gives no false edge
			rb_prev_reg <= 1'b1;
		end else begin
			rb_prev_reg <= i_ready_busy_input;
		end
	end

	assign rb_edge = ctl_reg[CTL_RB_EDGE]
		? (rb_prev_reg && !i_ready_busy_input)
		: (!rb_prev_reg && i_ready_busy_input);

	////////////////////////////////////////////////////////////////////////////
	// flash_status: sticky events, write 1 to clear, set wins

	// flags also clear on wake; the level bit follows the pin directly
	logic bad_flag_reg;
	logic rb_flag_reg;
	logic ecc_flag_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bad_flag_reg <= 1'b0;
			rb_flag_reg <= 1'b0;
			ecc_flag_reg <= 1'b0;
		end else if (i_wake) begin
			bad_flag_reg <= 1'b0;
			rb_flag_reg <= 1'b0;
			ecc_flag_reg <= 1'b0;
		end else begin
			if (bad_access) begin
				bad_flag_reg <= 1'b1;
			end else if (wr_stat && i_wdata[STAT_BAD_ACCESS]) begin
				bad_flag_reg <= 1'b0;
			end
			if (rb_edge) begin
				rb_flag_reg <= 1'b1;
			end else if (wr_stat && i_wdata[STAT_RB_EVENT]) begin
				rb_flag_reg <= 1'b0;
			end
			if (i_ecc_done) begin
				ecc_flag_reg <= 1'b1;
			end else if (wr_stat && i_wdata[STAT_ECC_DONE]) begin
				ecc_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ecc_done_irq <= 1'b0;
			o_bad_access_irq <= 1'b0;
			o_ready_busy_irq <= 1'b0;
		end else begin
			// event lines lag their flags by one cycle
			o_ecc_done_irq <= ecc_flag_reg && ctl_reg[CTL_ECC_IRQ_EN];
			o_bad_access_irq <= bad_flag_reg && ctl_reg[CTL_BAD_IRQ_EN];
			o_ready_busy_irq <= rb_flag_reg && ctl_reg[CTL_RB_IRQ_EN];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// chip selects

	// boot logic owns the first select while it is active
	logic cs_a_n;
	logic cs_b_n;

	always_comb begin
		if (i_boot_active) begin
			cs_a_n = i_boot_cs_a_n;
			cs_b_n = 1'b1;
		end else if (!ctl_reg[CTL_ENABLE]) begin
			cs_a_n = 1'b1;
			cs_b_n = 1'b1;
		end else begin
			cs_a_n = ctl_reg[CTL_CS_A];
			// second select yields whenever the first is requested
			cs_b_n = ctl_reg[CTL_CS_B] | ~ctl_reg[CTL_CS_A];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_chip_sel_a_out_n <= 1'b1;
			o_chip_sel_b_out_n <= 1'b1;
		end else begin
			o_chip_sel_a_out_n <= cs_a_n;
			o_chip_sel_b_out_n <= cs_b_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ECC engine controls

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_enable <= 1'b0;
			o_ecc_encode <= 1'b0;
			o_main_ecc_freeze <= 1'b1;
			o_spare_ecc_freeze <= 1'b1;
			o_octal_ecc_reinit <= 1'b0;
		end else begin
			// next value, so these settle in the cycle after the write
			o_enable <= ctl_next[CTL_ENABLE];
			o_ecc_encode <= ctl_next[CTL_ECC_DIR];
			o_main_ecc_freeze <= ctl_next[CTL_MAIN_FREEZE];
			o_spare_ecc_freeze <= ctl_next[CTL_SPARE_FREEZE];
			o_octal_ecc_reinit <= ctl_next[CTL_OCTAL_REINIT];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_main_ecc_clear <= 1'b0;
			o_spare_ecc_clear <= 1'b0;
		end else begin
			// one pulse per write of 1; the bits themselves are not stored
			o_main_ecc_clear <= wr_ctl && i_wdata[CTL_MAIN_CLEAR];
			o_spare_ecc_clear <= wr_ctl && i_wdata[CTL_SPARE_CLEAR];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port

	// read data stand for one cycle only, zero otherwise
	logic [31:0] rd_mux;
	logic [31:0] stat_word;

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[STAT_RB_LEVEL] = i_ready_busy_input;
		stat_word[STAT_RB_EVENT] = rb_flag_reg;
		stat_word[STAT_BAD_ACCESS] = bad_flag_reg;
		stat_word[STAT_ECC_DONE] = ecc_flag_reg;
		unique case (i_addr)
			ADDR_FLASH_CONTROL: rd_mux = ctl_reg;
			ADDR_UNLOCK_START: rd_mux = 32'(start_reg);
			ADDR_UNLOCK_END: rd_mux = 32'(end_reg);
			ADDR_FLASH_STATUS: rd_mux = stat_word;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= rd_mux;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule

// file: hw/nand_ctrl_pkg.sv
// Purpose: shared constants for the flash control and lock block
// Assumes: 32-bit register words at full byte addresses
// Notes: status bits other than the bad-access flag are placed locally
package nand_ctrl_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_FLASH_CONTROL = 32'h4E00_0004;
	localparam logic [31:0] ADDR_UNLOCK_START = 32'h4E00_0020;
	localparam logic [31:0] ADDR_UNLOCK_END = 32'h4E00_0024;
	localparam logic [31:0] ADDR_FLASH_STATUS = 32'h4E00_0028;

	// flash_control fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_CS_A = 1;
	localparam int CTL_CS_B = 2;
	localparam int CTL_SPARE_CLEAR = 4;
	localparam int CTL_MAIN_CLEAR = 5;
	localparam int CTL_SPARE_FREEZE = 6;
	localparam int CTL_MAIN_FREEZE = 7;
	localparam int CTL_RB_EDGE = 8;
	localparam int CTL_RB_IRQ_EN = 9;
	localparam int CTL_BAD_IRQ_EN = 10;
	localparam int CTL_OCTAL_REINIT = 11;
	localparam int CTL_ECC_IRQ_EN = 12;
	localparam int CTL_SOFT_LOCK = 16;
	localparam int CTL_STICKY_LOCK = 17;
	localparam int CTL_ECC_DIR = 18;
	localparam logic [31:0] CTL_RESET = 32'h0001_00C6;
	// bits that hold state; reserved and write-only bits read zero
	localparam logic [31:0] CTL_STORED = 32'h0007_1FC7;

	// flash_status fields
	localparam int STAT_RB_LEVEL = 0;
	localparam int STAT_RB_EVENT = 4;
	localparam int STAT_BAD_ACCESS = 5;
	localparam int STAT_ECC_DONE = 6;

	// block range reset value
	localparam logic [31:0] BLK_RESET = 32'h0000_0000;
	localparam int BLK_W_DOC = 24;
endpackage

// file: verification/ctl_checker_assertions.sv
// Purpose: checker for command verdicts, chip selects and control outputs
// Assumes: bound to the block's top module, ports matched by name
// Notes: control outputs settle one cycle after the write edge
`timescale 1ns/1ps
module ctl_checker
	import nand_ctrl_pkg::*;
#(
	parameter int BLK_W = 24
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register port
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	// command check
	input wire logic i_cmd_valid,
	input wire logic i_cmd_modify,
	input wire logic o_cmd_grant,
	input wire logic o_cmd_deny,
	// boot and chip selects
	input wire logic i_boot_active,
	input wire logic i_boot_cs_a_n,
	input wire logic o_chip_sel_a_out_n,
	input wire logic o_chip_sel_b_out_n,
	// control outputs
	input wire logic o_enable,
	input wire logic o_ecc_encode,
	input wire logic o_main_ecc_freeze,
	input wire logic o_spare_ecc_freeze,
	input wire logic o_main_ecc_clear,
	input wire logic o_spare_ecc_clear
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_ctl_wr;
		i_wr && i_addr == ADDR_FLASH_CONTROL;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_cmd_answer: assert property (i_cmd_valid |=> o_cmd_grant != o_cmd_deny)
		else $error("no single verdict");
	a_read_passes: assert property (i_cmd_valid && o_enable && !i_cmd_modify |=> o_cmd_grant)
		else $error("read refused");
	a_disabled_deny: assert property (i_cmd_valid && !o_enable |=> o_cmd_deny)
		else $error("disabled granted");
	a_cs_exclusive: assert property (o_chip_sel_a_out_n || o_chip_sel_b_out_n)
		else $error("both selects low");
	a_cs_disabled: assert property (!$past(o_enable) && !$past(i_boot_active)
		|-> o_chip_sel_a_out_n && o_chip_sel_b_out_n)
		else $error("select while disabled");
	a_boot_cs: assert property ($past(i_boot_active)
		|-> o_chip_sel_a_out_n == $past(i_boot_cs_a_n) && o_chip_sel_b_out_n)
		else $error("boot select wrong");
	a_clear_pulse: assert property (s_ctl_wr |=> o_main_ecc_clear == $past(i_wdata[CTL_MAIN_CLEAR])
		&& o_spare_ecc_clear == $past(i_wdata[CTL_SPARE_CLEAR]))
		else $error("clear pulse wrong");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside slot");
	a_ctl_outputs: assert property (s_ctl_wr |=> o_ecc_encode == $past(i_wdata[CTL_ECC_DIR])
		&& o_main_ecc_freeze == $past(i_wdata[CTL_MAIN_FREEZE])
		&& o_spare_ecc_freeze == $past(i_wdata[CTL_SPARE_FREEZE])
		&& o_enable == $past(i_wdata[CTL_ENABLE]))
		else $error("control output wrong");
endmodule

// file: verification/flash_chip_model.sv
// Purpose: flash chip stand-in driving the ready/busy line
// Assumes: the line has a pull-up, so idle reads ready
// Notes: busy starts only while some chip is selected
`timescale 1ns/1ps
module flash_chip_model #(
	parameter int BUSY_CYC = 3
) (
	// clock
	input wire logic i_clk,
	// selects and busy trigger
	input wire logic i_cs_a_n,
	input wire logic i_cs_b_n,
	input wire logic i_go,
	// ready/busy line
	output logic o_ready_busy
);
	int busy_cnt_reg = 0;
	always_ff @(posedge i_clk) begin
		if (i_go && !(i_cs_a_n && i_cs_b_n))
			busy_cnt_reg <= BUSY_CYC;
		else if (busy_cnt_reg != 0)
			busy_cnt_reg <= busy_cnt_reg - 1;
	end
	assign o_ready_busy = (busy_cnt_reg == 0);
endmodule

// file: verification/nand_ctrl_control_and_lock_bench.sv
// Purpose: self-checking bench for the flash control and lock block
// Assumes: 20 MHz clock, async active-high reset
// Notes: each scenario judges its own results
`timescale 1ns/1ps
bind nand_ctrl_control_and_lock ctl_checker #(.BLK_W(BLK_W)) chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .i_cmd_valid(i_cmd_valid), .i_cmd_modify(i_cmd_modify),
	.o_cmd_grant(o_cmd_grant), .o_cmd_deny(o_cmd_deny), .i_boot_active(i_boot_active),
	.i_boot_cs_a_n(i_boot_cs_a_n), .o_chip_sel_a_out_n(o_chip_sel_a_out_n),
	.o_chip_sel_b_out_n(o_chip_sel_b_out_n), .o_enable(o_enable),
	.o_ecc_encode(o_ecc_encode), .o_main_ecc_freeze(o_main_ecc_freeze),
	.o_spare_ecc_freeze(o_spare_ecc_freeze), .o_main_ecc_clear(o_main_ecc_clear),
	.o_spare_ecc_clear(o_spare_ecc_clear));
module nand_ctrl_control_and_lock_bench import nand_ctrl_pkg::*;;
	logic i_clk = 0, i_rst = 1, i_wake = 0, i_wr = 0, i_rd = 0, go = 0;
	logic [31:0] i_addr = 0, i_wdata = 0, o_rdata, v;
	logic i_cmd_valid = 0, i_cmd_modify = 0, i_boot_active = 0, i_boot_cs_a_n = 1;
	logic [7:0] i_cmd_block = 0;
	logic i_ecc_done = 0, i_ready_busy_input, o_cmd_grant, o_cmd_deny, o_enable;
	logic o_chip_sel_a_out_n, o_chip_sel_b_out_n, o_ecc_encode, o_octal_ecc_reinit;
	logic o_main_ecc_freeze, o_spare_ecc_freeze, o_main_ecc_clear, o_spare_ecc_clear;
	logic o_ecc_done_irq, o_bad_access_irq, o_ready_busy_irq;
	int errors = 0, total_checks = 0;
	nand_ctrl_control_and_lock #(.BLK_W(8)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_wake(i_wake),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cmd_valid(i_cmd_valid), .i_cmd_modify(i_cmd_modify), .i_cmd_block(i_cmd_block),
		.o_cmd_grant(o_cmd_grant), .o_cmd_deny(o_cmd_deny), .i_boot_active(i_boot_active),
		.i_boot_cs_a_n(i_boot_cs_a_n), .i_ready_busy_input(i_ready_busy_input),
		.i_ecc_done(i_ecc_done), .o_chip_sel_a_out_n(o_chip_sel_a_out_n),
		.o_chip_sel_b_out_n(o_chip_sel_b_out_n), .o_enable(o_enable),
		.o_ecc_encode(o_ecc_encode), .o_main_ecc_freeze(o_main_ecc_freeze),
		.o_spare_ecc_freeze(o_spare_ecc_freeze), .o_main_ecc_clear(o_main_ecc_clear),
		.o_spare_ecc_clear(o_spare_ecc_clear), .o_octal_ecc_reinit(o_octal_ecc_reinit),
		.o_ecc_done_irq(o_ecc_done_irq), .o_bad_access_irq(o_bad_access_irq),
		.o_ready_busy_irq(o_ready_busy_irq));
	flash_chip_model chip (.i_clk(i_clk), .i_cs_a_n(o_chip_sel_a_out_n),
		.i_cs_b_n(o_chip_sel_b_out_n), .i_go(go), .o_ready_busy(i_ready_busy_input));
	initial forever #25 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////////////
	task check(input string n, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task tick;
		@(posedge i_clk);
		#1;
	endtask
	task wr(input logic [31:0] a, d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
		#1;
	endtask
	task rd(input logic [31:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1 v = o_rdata;
	endtask
	task cmd(input logic m, input logic [7:0] b, input logic g);
		@(posedge i_clk);
		i_cmd_valid <= 1'h1;
		i_cmd_modify <= m;
		i_cmd_block <= b;
		@(posedge i_clk);
		i_cmd_valid <= 1'h0;
		#1 check("verdict", {o_cmd_grant, o_cmd_deny}, {g, !g});
	endtask
	task pulse_go;
		@(posedge i_clk);
		go <= 1'h1;
		@(posedge i_clk);
		go <= 1'h0;
		tick;
		tick;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(ADDR_FLASH_CONTROL);
		check("ctl", v, 32'h0001_00C6);
		check("outs", {o_chip_sel_a_out_n, o_chip_sel_b_out_n, o_enable}, 3'h6);
		rd(32'h4E00_0100);
		check("unmapped", v, 32'h0);
	endtask
	task t_lock;
		wr(ADDR_FLASH_CONTROL, 32'h0005_04F7);
		check("clr", {o_main_ecc_clear, o_spare_ecc_clear, o_ecc_encode}, 3'h7);
		rd(ADDR_FLASH_CONTROL);
		check("ctl", v, 32'h0005_04C7);
		wr(ADDR_UNLOCK_START, 32'h4);
		wr(ADDR_UNLOCK_END, 32'h8);
		cmd(1'h1, 8'h3, 1'h0);
		cmd(1'h1, 8'h4, 1'h1);
		cmd(1'h1, 8'h7, 1'h1);
		cmd(1'h1, 8'h8, 1'h0);
		cmd(1'h0, 8'h14, 1'h1);
		rd(ADDR_FLASH_STATUS);
		check("bad", v & 32'h20, 32'h20);
		check("badirq", o_bad_access_irq, 1'h1);
		wr(ADDR_FLASH_STATUS, 32'h20);
		wr(ADDR_UNLOCK_START, 32'h6);
		wr(ADDR_UNLOCK_END, 32'h6);
		cmd(1'h1, 8'h6, 1'h0);
		cmd(1'h1, 8'h0, 1'h0);
		wr(ADDR_FLASH_CONTROL, 32'h0000_00C7);
		cmd(1'h1, 8'h0, 1'h1);
		wr(ADDR_FLASH_CONTROL, 32'h0000_00C6);
		cmd(1'h0, 8'h0, 1'h0);
	endtask
	task t_cs;
		wr(ADDR_FLASH_CONTROL, 32'h0001_00C1);
		tick;
		check("cs", {o_chip_sel_a_out_n, o_chip_sel_b_out_n}, 2'h1);
		wr(ADDR_FLASH_CONTROL, 32'h0001_00C3);
		tick;
		check("cs", {o_chip_sel_a_out_n, o_chip_sel_b_out_n}, 2'h2);
		@(posedge i_clk);
		i_boot_active <= 1'h1;
		i_boot_cs_a_n <= 1'h0;
		tick;
		tick;
		check("cs", {o_chip_sel_a_out_n, o_chip_sel_b_out_n}, 2'h1);
		@(posedge i_clk);
		i_boot_active <= 1'h0;
		wr(ADDR_FLASH_CONTROL, 32'h0001_00C0);
		tick;
		check("cs", {o_chip_sel_a_out_n, o_chip_sel_b_out_n}, 2'h3);
	endtask
	task t_events;
		wr(ADDR_FLASH_CONTROL, 32'h0001_02C5);
		pulse_go;
		check("rbirq", o_ready_busy_irq, 1'h0);
		repeat (6) tick;
		check("rbirq", o_ready_busy_irq, 1'h1);
		wr(ADDR_FLASH_STATUS, 32'h10);
		wr(ADDR_FLASH_CONTROL, 32'h0001_03C5);
		check("rbirq", o_ready_busy_irq, 1'h0);
		pulse_go;
		check("rbirq", o_ready_busy_irq, 1'h1);
		@(posedge i_clk);
		i_ecc_done <= 1'h1;
		@(posedge i_clk);
		i_ecc_done <= 1'h0;
		tick;
		check("eccirq", o_ecc_done_irq, 1'h0);
		wr(ADDR_FLASH_CONTROL, 32'h0001_18C7);
		tick;
		check("eccirq", o_ecc_done_irq, 1'h1);
		check("reinit", o_octal_ecc_reinit, 1'h1);
	endtask
	task t_sticky;
		wr(ADDR_UNLOCK_START, 32'h2);
		wr(ADDR_FLASH_CONTROL, 32'h0003_00C7);
		wr(ADDR_UNLOCK_START, 32'h9);
		rd(ADDR_UNLOCK_START);
		check("start", v, 32'h2);
		wr(ADDR_FLASH_CONTROL, 32'h0000_00C7);
		cmd(1'h1, 8'h1, 1'h0);
		rd(ADDR_FLASH_CONTROL);
		check("sticky", v & 32'h0002_0000, 32'h0002_0000);
		@(posedge i_clk);
		i_wake <= 1'h1;
		@(posedge i_clk);
		i_wake <= 1'h0;
		rd(ADDR_FLASH_CONTROL);
		check("ctl", v, 32'h0001_00C6);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'h0;
		t_reset;
		t_lock;
		t_cs;
		t_events;
		t_sticky;
		complete_run;
	end
	initial begin
		#(50 * 2000);
		errors++;
		complete_run;
	end
endmodule
